// >>> rtl/dual_core_interrupt_routing.sv
`timescale 1ns/1ns
module dual_core_interrupt_routing
   import irq_route_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Interrupt sources
   input wire logic [irq_route_pkg::NUM_SOURCES-1:0] src_irq,
   // Routing table write port
   input wire logic cfg_we,
   input wire logic [irq_route_pkg::SRC_IDX_W-1:0] cfg_src,
   input wire logic [irq_route_pkg::ENTRY_W-1:0] cfg_entry,
   output logic cfg_ready,
   // Secondary core priorities, lines 0..7 then software 0..7
   input wire logic [irq_route_pkg::SEC_CAND*irq_route_pkg::SEC_PRIO_W-1:0] sec_prio,
   // Software interrupts of the secondary core
   input wire logic [irq_route_pkg::SW_IRQS-1:0] sw_set,
   input wire logic [irq_route_pkg::SW_IRQS-1:0] sw_clr,
   // NMI selection per core
   input wire logic [irq_route_pkg::NMI_SLOTS*irq_route_pkg::SRC_IDX_W-1:0] main_nmi_sel,
   input wire logic [irq_route_pkg::NMI_SLOTS-1:0] main_nmi_en,
   input wire logic [irq_route_pkg::NMI_SLOTS*irq_route_pkg::SRC_IDX_W-1:0] sec_nmi_sel,
   input wire logic [irq_route_pkg::NMI_SLOTS-1:0] sec_nmi_en,
   // Deep Sleep wake control per core
   input wire logic main_deep_sleep,
   input wire logic sec_deep_sleep,
   input wire logic [irq_route_pkg::WAKE_SOURCES-1:0] main_wake_mask,
   input wire logic [irq_route_pkg::WAKE_SOURCES-1:0] sec_wake_mask,
   // Main core
   output logic [irq_route_pkg::NUM_SOURCES-1:0] main_irq,
   output logic main_pend_valid,
   output logic [irq_route_pkg::SRC_IDX_W-1:0] main_pend_id,
   output logic [irq_route_pkg::MAIN_PRIO_W-1:0] main_pend_prio,
   output logic main_nmi,
   output logic main_wake,
   // Secondary core
   output logic [irq_route_pkg::SEC_LINES-1:0] sec_irq,
   output logic [irq_route_pkg::SW_IRQS-1:0] sw_pend,
   output logic sec_pend_valid,
   output logic [irq_route_pkg::SEC_ID_W-1:0] sec_pend_id,
   output logic [irq_route_pkg::SEC_PRIO_W-1:0] sec_pend_prio,
   output logic sec_nmi,
   output logic sec_wake
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic nmi_hit(input logic [NUM_SOURCES-1:0] srcs,
                                    input logic [NMI_SLOTS*SRC_IDX_W-1:0] sel,
                                    input logic [NMI_SLOTS-1:0] en);
      logic hit;
      logic [SRC_IDX_W-1:0] idx;
      hit = 1'b0;
      for (int s = 0; s < NMI_SLOTS; s++)
      begin
         idx = sel[s*SRC_IDX_W +: SRC_IDX_W];
         if (en[s] && (int'(idx) < NUM_SOURCES) && srcs[idx])
            hit = 1'b1;
      end
      return hit;
   endfunction : nmi_hit
   localparam logic [SRC_IDX_W-1:0] LAST_IDX = SRC_IDX_W'(NUM_SOURCES - 1);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   scan_state_t state, next_state;
   logic [SRC_IDX_W-1:0] scan_idx, next_scan_idx;
   logic eval_vld, next_eval_vld;
   logic [SRC_IDX_W-1:0] eval_idx, next_eval_idx;
   logic [SEC_LINES-1:0] acc_lines, next_acc_lines;
   logic acc_found, next_acc_found;
   logic [SRC_IDX_W-1:0] acc_id, next_acc_id;
   logic [MAIN_PRIO_W-1:0] acc_prio, next_acc_prio, next_main_pend_prio;
   logic [NUM_SOURCES-1:0] src_q;
   logic [SEC_LINES-1:0] next_sec_irq;
   logic next_main_pend_valid, next_cfg_ready, mem_we, next_sec_pend_valid;
   logic [SRC_IDX_W-1:0] next_main_pend_id, mem_waddr;
   logic [ENTRY_W-1:0] mem_wdata, entry;
   logic [SW_IRQS-1:0] next_sw_pend;
   logic [SEC_ID_W-1:0] next_sec_pend_id;
   logic [SEC_PRIO_W-1:0] next_sec_pend_prio;

   // ------------------------------------------------------------
   // Routing table
   // ------------------------------------------------------------
   route_table_mem #(.WIDTH(ENTRY_W), .DEPTH(NUM_SOURCES), .ADDR_W(SRC_IDX_W)) u_table
   (
      .core_clk(core_clk),
      .wr_en(mem_we),
      .wr_addr(mem_waddr),
      .wr_data(mem_wdata),
      .rd_addr(scan_idx),
      .rd_data(entry)
   );

   // ------------------------------------------------------------
   // Table scanner: secondary mapping and main arbitration
   // ------------------------------------------------------------
   always_comb
   begin
      logic pend;
      logic [LINE_W-1:0] line;
      logic [MAIN_PRIO_W-1:0] prio;
      pend = 1'b0;
      line = '0;
      prio = '0;
      next_state = state;
      next_scan_idx = scan_idx;
      next_eval_vld = 1'b0;
      next_eval_idx = scan_idx;
      next_acc_lines = acc_lines;
      next_acc_found = acc_found;
      next_acc_id = acc_id;
      next_acc_prio = acc_prio;
      next_sec_irq = sec_irq;
      next_main_pend_valid = main_pend_valid;
      next_main_pend_id = main_pend_id;
      next_main_pend_prio = main_pend_prio;
      next_cfg_ready = cfg_ready;
      // Reset sweep clears the table; writes are dropped until it ends
      mem_we = cfg_we && cfg_ready;
      mem_waddr = cfg_src;
      mem_wdata = cfg_entry;
      // Fold in the entry read last cycle
      if (eval_vld)
      begin
         pend = src_q[eval_idx];
         line = entry[ENT_LINE_LSB +: LINE_W];
         prio = entry[ENT_PRIO_LSB +: MAIN_PRIO_W];
         if (pend && entry[ENT_SEC_EN_BIT])
            next_acc_lines[line] = 1'b1;
         if (pend && (!acc_found || (prio < acc_prio)))
         begin
            next_acc_found = 1'b1;
            next_acc_id = eval_idx;
            next_acc_prio = prio;
         end
      end
      case (state)
         ST_INIT:
         begin
            mem_we = 1'b1;
            mem_waddr = scan_idx;
            mem_wdata = ENTRY_RESET;
            next_scan_idx = scan_idx + 1'b1;
            if (scan_idx == LAST_IDX)
            begin
               next_scan_idx = '0;
               next_cfg_ready = 1'b1;
               next_state = ST_SCAN;
            end
         end
         ST_SCAN:
         begin
            next_eval_vld = 1'b1;
            next_scan_idx = scan_idx + 1'b1;
            if (scan_idx == LAST_IDX)
            begin
               next_scan_idx = '0;
               next_state = ST_WRAP;
            end
         end
         ST_WRAP:
         begin
            // Publish the sweep and start a new one
            next_sec_irq = next_acc_lines;
            next_main_pend_valid = next_acc_found;
            next_main_pend_id = next_acc_id;
            next_main_pend_prio = next_acc_prio;
            next_acc_lines = '0;
            next_acc_found = 1'b0;
            next_acc_id = '0;
            next_acc_prio = '0;
            next_state = ST_SCAN;
         end
         default:
         begin
            next_state = ST_INIT;
            next_scan_idx = '0;
         end
      endcase
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state <= ST_INIT;
         scan_idx <= '0;
         eval_vld <= 1'b0;
         eval_idx <= '0;
         acc_lines <= '0;
         acc_found <= 1'b0;
         acc_id <= '0;
         acc_prio <= '0;
         sec_irq <= '0;
         main_pend_valid <= 1'b0;
         main_pend_id <= '0;
         main_pend_prio <= '0;
         cfg_ready <= 1'b0;
      end
      else
      begin
         state <= next_state;
         scan_idx <= next_scan_idx;
         eval_vld <= next_eval_vld;
         eval_idx <= next_eval_idx;
         acc_lines <= next_acc_lines;
         acc_found <= next_acc_found;
         acc_id <= next_acc_id;
         acc_prio <= next_acc_prio;
         sec_irq <= next_sec_irq;
         main_pend_valid <= next_main_pend_valid;
         main_pend_id <= next_main_pend_id;
         main_pend_prio <= next_main_pend_prio;
         cfg_ready <= next_cfg_ready;
      end
   end

   // ------------------------------------------------------------
   // Secondary core software interrupts and arbitration
   // ------------------------------------------------------------
   always_comb
   begin
      logic [SEC_CAND-1:0] cand;
      logic [SEC_PRIO_W-1:0] p;
      cand = {sw_pend, sec_irq};
      p = '0;
      // Set wins over a clear in the same cycle
      next_sw_pend = (sw_pend & ~sw_clr) | sw_set;
      next_sec_pend_valid = 1'b0;
      next_sec_pend_id = '0;
      next_sec_pend_prio = '0;
      for (int c = 0; c < SEC_CAND; c++)
      begin
         p = sec_prio[c*SEC_PRIO_W +: SEC_PRIO_W];
         if (cand[c] && (!next_sec_pend_valid || (p < next_sec_pend_prio)))
         begin
            next_sec_pend_valid = 1'b1;
            next_sec_pend_id = SEC_ID_W'(c);
            next_sec_pend_prio = p;
         end
      end
   end
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         sw_pend <= '0;
         sec_pend_valid <= 1'b0;
         sec_pend_id <= '0;
         sec_pend_prio <= '0;
      end
      else
      begin
         sw_pend <= next_sw_pend;
         sec_pend_valid <= next_sec_pend_valid;
         sec_pend_id <= next_sec_pend_id;
         sec_pend_prio <= next_sec_pend_prio;
      end
   end

   // ------------------------------------------------------------
   // Direct lines, NMI and wake
   // ------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         src_q <= '0;
         main_irq <= '0;
         main_nmi <= 1'b0;
         sec_nmi <= 1'b0;
         main_wake <= 1'b0;
         sec_wake <= 1'b0;
      end
      else
      begin
         src_q <= src_irq;
         main_irq <= src_irq;
         main_nmi <= nmi_hit(src_irq, main_nmi_sel, main_nmi_en);
         sec_nmi <= nmi_hit(src_irq, sec_nmi_sel, sec_nmi_en);
         main_wake <= main_deep_sleep && |(src_irq[WAKE_SOURCES-1:0] & main_wake_mask);
         sec_wake <= sec_deep_sleep && |(src_irq[WAKE_SOURCES-1:0] & sec_wake_mask);
      end
   end
endmodule : dual_core_interrupt_routing

// >>> shared/irq_route_pkg.sv
package irq_route_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int NUM_SOURCES = 174;
   localparam int SRC_IDX_W = 8;
   localparam int SEC_LINES = 8;
   localparam int LINE_W = 3;
   localparam int SW_IRQS = 8;
   localparam int SEC_CAND = 16;
   localparam int SEC_ID_W = 4;
   localparam int MAIN_PRIO_W = 3;
   localparam int SEC_PRIO_W = 2;
   localparam int NMI_SLOTS = 4;
   localparam int WAKE_SOURCES = 39;

   // ------------------------------------------------------------
   // Per-source routing entry layout
   // ------------------------------------------------------------
   localparam int ENT_PRIO_LSB = 0;
   localparam int ENT_LINE_LSB = 3;
   localparam int ENT_SEC_EN_BIT = 6;
   localparam int ENTRY_W = 7;
   // Not routed to the secondary core, lowest main priority
   localparam logic [ENTRY_W-1:0] ENTRY_RESET = 7'h07;

   // ------------------------------------------------------------
   // Scanner states
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_INIT = 3'b001,
      ST_SCAN = 3'b010,
      ST_WRAP = 3'b100
   } scan_state_t;

endpackage : irq_route_pkg

// >>> rtl/route_table_mem.sv
`timescale 1ns/1ns
module route_table_mem
#(
   parameter int WIDTH = 7,
   parameter int DEPTH = 174,
   parameter int ADDR_W = 8
)
(
   // Clock
   input wire logic core_clk,
   // Write port
   input wire logic wr_en,
   input wire logic [ADDR_W-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // Read port, data one cycle after address
   input wire logic [ADDR_W-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge core_clk)
   begin
      if (wr_en && (int'(wr_addr) < DEPTH))
      begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end

endmodule : route_table_mem

// >>> sim/irq_source_model.sv
`timescale 1ns/1ns
module irq_source_model
   import irq_route_pkg::*;
(
   // Clock
   input wire logic core_clk,
   // Levels asked for by the bench
   input wire logic [irq_route_pkg::NUM_SOURCES-1:0] want,
   // Source lines
   output logic [irq_route_pkg::NUM_SOURCES-1:0] src_irq
);
   // Peripherals move their lines just after the rising edge
   always_ff @(posedge core_clk)
      src_irq <= want;
endmodule : irq_source_model

// >>> sim/route_chk.sv
`timescale 1ns/1ns
module route_chk
   import irq_route_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Inputs
   input wire logic [irq_route_pkg::NUM_SOURCES-1:0] src_irq,
   input wire logic [irq_route_pkg::SW_IRQS-1:0] sw_set,
   input wire logic [irq_route_pkg::SW_IRQS-1:0] sw_clr,
   input wire logic [irq_route_pkg::SEC_CAND*irq_route_pkg::SEC_PRIO_W-1:0] sec_prio,
   input wire logic [irq_route_pkg::NMI_SLOTS*irq_route_pkg::SRC_IDX_W-1:0] main_nmi_sel,
   input wire logic [irq_route_pkg::NMI_SLOTS-1:0] main_nmi_en,
   input wire logic main_deep_sleep,
   input wire logic [irq_route_pkg::WAKE_SOURCES-1:0] main_wake_mask,
   // Outputs
   input wire logic [irq_route_pkg::NUM_SOURCES-1:0] main_irq,
   input wire logic main_pend_valid,
   input wire logic main_nmi,
   input wire logic main_wake,
   input wire logic [irq_route_pkg::SEC_LINES-1:0] sec_irq,
   input wire logic [irq_route_pkg::SW_IRQS-1:0] sw_pend,
   input wire logic sec_pend_valid,
   input wire logic [irq_route_pkg::SEC_ID_W-1:0] sec_pend_id,
   input wire logic [irq_route_pkg::SEC_PRIO_W-1:0] sec_pend_prio
);
   logic [8:0] q_cnt;
   logic [8:0] next_q_cnt;
   logic exp_nmi;
   logic next_exp_nmi;
   logic exp_wake;
   logic next_exp_wake;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   // Quiet-time counter and one-cycle expectations
   always_comb
   begin
      next_q_cnt = (src_irq != '0) ? 9'h000 : q_cnt + {8'h00, q_cnt < 9'h190};
      next_exp_nmi = 1'b0;
      for (int k = 0; k < NMI_SLOTS; k++)
         if (main_nmi_en[k] && main_nmi_sel[k*8 +: 8] < 8'hAE)
            next_exp_nmi = next_exp_nmi | src_irq[main_nmi_sel[k*8 +: 8]];
      next_exp_wake = main_deep_sleep && ((src_irq[38:0] & main_wake_mask) != '0);
   end
   always_ff @(posedge core_clk)
   begin
      q_cnt <= rst ? 9'h000 : next_q_cnt;
      exp_nmi <= next_exp_nmi;
      exp_wake <= next_exp_wake;
   end
   sequence s_quiet;
      q_cnt >= 9'h168;
   endsequence
   sequence s_sec_req;
      ($past(sw_pend) != '0) || ($past(sec_irq) != '0);
   endsequence
   property p_main_copy;
      !$past(rst) |-> main_irq == $past(src_irq);
   endproperty
   a_main_copy: assert property (p_main_copy) else $error("main line copy differs");
   property p_quiet;
      s_quiet |-> sec_irq == '0 && !main_pend_valid;
   endproperty
   a_quiet: assert property (p_quiet) else $error("line up with no source");
   property p_sw_set;
      sw_set[2] |=> sw_pend[2];
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("software set lost");
   property p_sw_clr;
      sw_clr[2] && !sw_set[2] |=> !sw_pend[2];
   endproperty
   a_sw_clr: assert property (p_sw_clr) else $error("software clear lost");
   property p_sec_valid;
      s_sec_req |-> sec_pend_valid;
   endproperty
   a_sec_valid: assert property (p_sec_valid) else $error("secondary pending lost");
   property p_sec_idle;
      !$past(rst) && ($past(sw_pend) == '0) && ($past(sec_irq) == '0) |-> !sec_pend_valid;
   endproperty
   a_sec_idle: assert property (p_sec_idle) else $error("secondary pending with no request");
   property p_sec_prio;
      sec_pend_valid && $stable(sec_prio) |-> sec_pend_prio == sec_prio[sec_pend_id*2 +: 2];
   endproperty
   a_sec_prio: assert property (p_sec_prio) else $error("secondary priority wrong");
   property p_main_nmi;
      !$past(rst) |-> main_nmi == exp_nmi;
   endproperty
   a_main_nmi: assert property (p_main_nmi) else $error("main nmi wrong");
   property p_main_wake;
      !$past(rst) |-> main_wake == exp_wake;
   endproperty
   a_main_wake: assert property (p_main_wake) else $error("main wake wrong");
endmodule : route_chk
bind dual_core_interrupt_routing route_chk u_chk (.core_clk, .rst, .src_irq, .sw_set, .sw_clr, .sec_prio,
   .main_nmi_sel, .main_nmi_en, .main_deep_sleep, .main_wake_mask, .main_irq, .main_pend_valid, .main_nmi,
   .main_wake, .sec_irq, .sw_pend, .sec_pend_valid, .sec_pend_id, .sec_pend_prio);

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import irq_route_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [NUM_SOURCES-1:0] want = '0;
   logic [NUM_SOURCES-1:0] src_irq, main_irq;
   logic cfg_we = 1'b0;
   logic [7:0] cfg_src = 8'h00;
   logic [6:0] cfg_entry = 7'h00;
   logic [31:0] sec_prio = 32'hFF1FFFFF;
   logic [7:0] sw_set = 8'h00;
   logic [7:0] sw_clr = 8'h00;
   logic [31:0] main_nmi_sel = 32'hADC80503;
   logic [3:0] main_nmi_en = 4'hD;
   logic [31:0] sec_nmi_sel = 32'h0A0A0A07;
   logic [3:0] sec_nmi_en = 4'h1;
   logic main_deep_sleep = 1'b0;
   logic sec_deep_sleep = 1'b0;
   logic [38:0] main_wake_mask = 39'h4000000000;
   logic [38:0] sec_wake_mask = 39'h0000000001;
   logic cfg_ready, main_pend_valid, main_nmi, main_wake, sec_pend_valid, sec_nmi, sec_wake;
   logic [7:0] main_pend_id, sec_irq, sw_pend;
   logic [2:0] main_pend_prio;
   logic [3:0] sec_pend_id;
   logic [1:0] sec_pend_prio;
   int mismatches = 0;
   int cmp_count = 0;
   always #25 core_clk = ~core_clk;
   irq_source_model src_model (.core_clk, .want, .src_irq);
   dual_core_interrupt_routing DUT (.core_clk, .rst, .src_irq, .cfg_we, .cfg_src, .cfg_entry, .cfg_ready,
      .sec_prio, .sw_set, .sw_clr, .main_nmi_sel, .main_nmi_en, .sec_nmi_sel, .sec_nmi_en, .main_deep_sleep,
      .sec_deep_sleep, .main_wake_mask, .sec_wake_mask, .main_irq, .main_pend_valid, .main_pend_id,
      .main_pend_prio, .main_nmi, .main_wake, .sec_irq, .sw_pend, .sec_pend_valid, .sec_pend_id,
      .sec_pend_prio, .sec_nmi, .sec_wake);
   task automatic chk(input logic [NUM_SOURCES-1:0] got, input logic [NUM_SOURCES-1:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask : tick
   task automatic wr(input logic [7:0] s, input logic [6:0] e);
      cfg_we = 1'b1;
      cfg_src = s;
      cfg_entry = e;
      tick(1);
   endtask : wr
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic t_direct();
      want = {1'b1, 72'h0, 1'b1, 99'h0, 1'b1};
      tick(2);
      chk(main_irq, want);
      want = '0;
      tick(2);
      chk(main_irq, want);
   endtask : t_direct
   task automatic t_nmi();
      want[5] = 1'b1;
      tick(2);
      chk(main_nmi, 1'b0);
      want[3] = 1'b1;
      tick(2);
      chk(main_nmi, 1'b1);
      want = '0;
      want[7] = 1'b1;
      tick(2);
      chk({main_nmi, sec_nmi}, 2'h1);
   endtask : t_nmi
   task automatic t_wake();
      main_deep_sleep = 1'b1;
      sec_deep_sleep = 1'b1;
      want = '0;
      want[39] = 1'b1;
      tick(2);
      chk({main_wake, sec_wake}, 2'h0);
      want[38] = 1'b1;
      want[0] = 1'b1;
      tick(2);
      chk({main_wake, sec_wake}, 2'h3);
      main_deep_sleep = 1'b0;
      tick(1);
      chk({main_wake, sec_wake}, 2'h1);
      want = '0;
   endtask : t_wake
   task automatic t_sw();
      sw_set = 8'h04;
      tick(1);
      sw_set = 8'h08;
      sw_clr = 8'h08;
      chk(sw_pend, 8'h04);
      tick(1);
      sw_set = 8'h00;
      sw_clr = 8'h0C;
      chk({sw_pend, sec_pend_valid, sec_pend_id, sec_pend_prio}, {8'h0C, 7'h69});
      tick(1);
      sw_clr = 8'h00;
      chk({sw_pend, sec_pend_valid, sec_pend_id}, {8'h00, 5'h1B});
      tick(1);
      chk(sec_pend_valid, 1'b0);
   endtask : t_sw
   task automatic t_route();
      for (int i = 0; i < 400 && cfg_ready !== 1'b1; i++)
         tick(1);
      chk(cfg_ready, 1'b1);
      wr(8'h05, 7'h48);
      wr(8'h09, 7'h4A);
      wr(8'hAA, 7'h01);
      wr(8'hC8, 7'h78);
      cfg_we = 1'b0;
      want[9] = 1'b1;
      want[0] = 1'b1;
      tick(360);
      chk({sec_irq, main_pend_valid, main_pend_id, main_pend_prio}, {8'h02, 12'h84A});
      chk({sec_pend_valid, sec_pend_id, sec_pend_prio}, 7'h47);
      want[170] = 1'b1;
      tick(360);
      chk({main_pend_valid, main_pend_id, main_pend_prio}, 12'hD51);
      want = '0;
      want[5] = 1'b1;
      tick(360);
      chk({sec_irq, main_pend_valid, main_pend_id, main_pend_prio}, {8'h02, 12'h828});
      want = '0;
      tick(370);
      chk({sec_irq, main_pend_valid}, 9'h000);
   endtask : t_route
   initial
   begin
      repeat (6000) @(posedge core_clk);
      mismatches++;
      conclude();
   end
   initial
   begin
      tick(20);
      rst = 1'b0;
      // Refused while the table is still being cleared
      wr(8'h00, 7'h78);
      cfg_we = 1'b0;
      chk(cfg_ready, 1'b0);
      t_direct();
      t_nmi();
      t_wake();
      t_sw();
      t_route();
      conclude();
   end
endmodule : tb_top
